/* File: core/hdlc_channel_event_errors.sv */
// per-channel event detection, ss7 monitor and transmit error handling
//
// Our own choices: the register addresses and register access over AHB-Lite.
`include "hdlc_event_defs.svh"
// Behaviour
// RULE1: fill to abort queues change-to-abort unless masked
// RULE2: abort to fill queues change-to-idle unless masked
// RULE3: out-of-frame to in-frame queues recovery event
// RULE4: informational events never stop normal handling
// RULE5: ss7 errors increment counter, queue increment event
// RULE6: 256 clean messages decrement counter, queue event
// RULE7: repeated 3-5 octet clean message is filtered
// RULE8: filtered duplicate dropped, not sent to host
// RULE9: eom zero, next host-owned gives ownership error
// RULE10: granted buffer fetched until its end
// RULE11: host never reclaims a granted buffer
// RULE12: ownership error queued, direction one, maskable
// RULE13: transmit error sends repeated sixteen ones abort
// RULE14: no status write on ownership error
// RULE15: transmit error stops descriptor polling
// RULE16: fifo empty while owning buffer is under-run
// RULE17: under-run queued, direction one, no status write
// RULE18: host reactivates channel after transmit error
// RULE19: direction one transmit, zero receive
// RULE20: abort state holds until host reactivation
module hdlc_channel_event_errors
   import hdlc_event_pkg::*;
#(
   parameter int QDEPTH = 8
) (
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic             hreadyout,
   output logic             hresp,
   output logic      [31:0] hrdata,
   input  wire logic        rx_octet_valid,
   input  wire logic [7:0]  rx_octet,
   input  wire logic        in_frame,
   input  wire logic        msg_end,
   input  wire logic        msg_error,
   input  wire logic [3:0]  msg_len,
   input  wire logic [39:0] msg_data,
   output logic             msg_drop,
   input  wire logic        buf_done,
   input  wire logic        end_of_message_flag,
   input  wire logic        next_owned,
   input  wire logic        fifo_empty,
   input  wire logic        bit_needed,
   output logic             fetch_enable,
   output logic             poll_enable,
   output logic             status_write_enable,
   output logic             tx_abort_bit
);
   logic [31:0]      chan_cfg;
   logic [7:0]       error_count;
   logic [8:0]       clean_count;
   logic [1:0]       rx_pattern;
   logic             last_frame;
   logic [39:0]      last_msg;
   logic [3:0]       last_len;
   logic             last_valid;
   tx_state_t        tx_state;
   logic [4:0]       ones_count;
   logic [2:0]       wptr, rptr;
   logic [3:0]       qcount;
   logic [5:0]       qrdata;
   logic             ap_write, ap_read;
   logic [7:0]       ap_addr;
   logic             ev_valid;
   logic [5:0]       ev_word;
   logic             pop;

   function automatic logic [5:0] pack_event(input event_code_t c, input logic dir);
      pack_event = {dir, c};
   endfunction

   ////////////////////////////////////////////////////////////////
   // ahb-lite slave, zero wait states, always okay
   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ap_write <= 1'b0;
         ap_read  <= 1'b0;
         ap_addr  <= 8'h00;
      end else if (hready) begin
         ap_write <= hsel & htrans[1] & hwrite;
         ap_read  <= hsel & htrans[1] & ~hwrite;
         ap_addr  <= haddr[7:0];
      end
   end
   wire cfg_write = ap_write && ap_addr == `OFS_CHAN_CFG;
   // config register; reactivate bit is self clearing
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         chan_cfg <= `CHAN_CFG_RESET;
      end else if (cfg_write) begin
         chan_cfg <= hwdata & 32'h0000_007f;
      end
   end
   wire reactivate = cfg_write & hwdata[`BIT_REACTIVATE];
   assign pop = ap_read && ap_addr == `OFS_EVT_QUEUE && qcount != 4'h0;
   // read mux; unmapped reads as zero
   always_comb begin
      case (ap_addr)
         `OFS_CHAN_CFG:  hrdata = chan_cfg;
         `OFS_RX_STATUS: hrdata = {23'h0, error_count, in_frame};
         `OFS_TX_STATUS: hrdata = {27'h0, ones_count[0], tx_state, fetch_enable};
         `OFS_EVT_QUEUE: hrdata = {25'h0, qcount != 4'h0, qrdata};
         `OFS_EVT_COUNT: hrdata = {28'h0, qcount};
         default:        hrdata = 32'h0;
      endcase
   end

   ////////////////////////////////////////////////////////////////
   // receive idle/abort pattern tracking
   wire is_fill  = rx_octet_valid && rx_octet == `FILL_OCTET;
   wire is_abort = rx_octet_valid && rx_octet == `ABORT_OCTET;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         rx_pattern <= 2'b00;
      end else if (is_fill) begin
         rx_pattern <= 2'b01;
      end else if (is_abort) begin
         rx_pattern <= 2'b10;
      end
   end
   wire ev_abort = is_abort && rx_pattern == 2'b01; // RULE1
   wire ev_idle  = is_fill && rx_pattern == 2'b10;  // RULE2
   // frame state edge
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         last_frame <= 1'b1;
      end else begin
         last_frame <= in_frame;
      end
   end
   wire ev_frame_recovery_event = in_frame & ~last_frame; // RULE3

   ////////////////////////////////////////////////////////////////
   // ss7 error-rate counter and duplicate filter
   wire ss7      = chan_cfg[`BIT_SS7_MODE];
   wire end_bad  = ss7 & msg_end & msg_error;
   wire end_good = ss7 & msg_end & ~msg_error;
   wire dec_hit  = end_good && clean_count == `CLEAN_RUN - 9'h1;
   wire ev_inc   = end_bad;                                // RULE5
   wire ev_dec   = dec_hit && error_count != 8'h00;        // RULE6
   wire ev_filt  = end_good && last_valid && msg_len >= `MIN_FILT_LEN
                   && msg_len <= `MAX_FILT_LEN && msg_len == last_len
                   && msg_data == last_msg;                // RULE7
   assign msg_drop = ev_filt; // RULE8
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         error_count <= 8'h00;
      end else if (ev_inc && error_count != 8'hff) begin
         error_count <= error_count + 8'h01; // RULE5
      end else if (ev_dec) begin
         error_count <= error_count - 8'h01; // RULE6
      end
   end
   // run of clean messages, broken by any error
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         clean_count <= 9'h000;
      end else if (end_bad || dec_hit) begin
         clean_count <= 9'h000;
      end else if (end_good) begin
         clean_count <= clean_count + 9'h001;
      end
   end
   // last message memory; errored message breaks comparison
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         last_msg   <= 40'h0;
         last_len   <= 4'h0;
         last_valid <= 1'b0;
      end else if (end_good) begin
         last_msg   <= msg_data;
         last_len   <= msg_len;
         last_valid <= 1'b1;
      end else if (end_bad) begin
         last_valid <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////
   // transmit error detection and abort state
   wire err_onr  = tx_state == TX_RUN && buf_done && !end_of_message_flag && !next_owned; // RULE9
   wire err_fifo = tx_state == TX_RUN && fifo_empty && bit_needed && !err_onr; // RULE16
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         tx_state <= TX_IDLE;
      end else begin
         case (tx_state)
            TX_IDLE:  if (reactivate) tx_state <= TX_RUN;
            TX_RUN:   if (err_onr || err_fifo) tx_state <= TX_ABORT; // RULE13
            TX_ABORT: if (reactivate) tx_state <= TX_RUN; // RULE20 RULE18
            default:  tx_state <= TX_IDLE;
         endcase
      end
   end
   // fetch runs to buffer end while running; stops on error
   assign fetch_enable = tx_state == TX_RUN; // RULE10 RULE20
   assign poll_enable  = tx_state == TX_RUN; // RULE15
   // status descriptor suppressed on both error kinds
   assign status_write_enable = tx_state == TX_RUN && buf_done && !err_onr && !err_fifo; // RULE14 RULE17
   // sixteen-ones abort pattern counter, repeats while aborting
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ones_count   <= 5'h00;
         tx_abort_bit <= 1'b0;
      end else if (tx_state == TX_ABORT && bit_needed) begin
         tx_abort_bit <= 1'b1; // RULE13
         ones_count   <= (ones_count == `ABORT_ONES - 5'h1) ? 5'h00 : ones_count + 5'h01;
      end else if (tx_state != TX_ABORT) begin
         ones_count   <= 5'h00;
         tx_abort_bit <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////
   // event selection, one per cycle, errors first
   always_comb begin
      ev_valid = 1'b1;
      if (err_onr && !chan_cfg[`BIT_BUFERR_MASK]) begin
         ev_word = pack_event(ER_OWNERSHIP, 1'b1); // RULE12 RULE19
      end else if (err_fifo && !chan_cfg[`BIT_BUFERR_MASK]) begin
         ev_word = pack_event(ER_FIFO_RUN, 1'b1); // RULE17 RULE19
      end else if (ev_abort && !chan_cfg[`BIT_IDLE_MASK]) begin
         ev_word = pack_event(EV_CHANGE_ABORT, 1'b0); // RULE1 RULE19
      end else if (ev_idle && !chan_cfg[`BIT_IDLE_MASK]) begin
         ev_word = pack_event(EV_CHANGE_IDLE, 1'b0); // RULE2
      end else if (ev_frame_recovery_event && !chan_cfg[`BIT_FLOSS_MASK]) begin
         ev_word = pack_event(EV_FRAME_REC, 1'b0); // RULE3
      end else if (ev_inc && !chan_cfg[`BIT_INC_MASK]) begin
         ev_word = pack_event(EV_INCREMENT, 1'b0); // RULE5
      end else if (ev_dec && !chan_cfg[`BIT_DEC_MASK]) begin
         ev_word = pack_event(EV_DECREMENT, 1'b0); // RULE6
      end else if (ev_filt && !chan_cfg[`BIT_FILT_MASK]) begin
         ev_word = pack_event(EV_FILTERED, 1'b0); // RULE7
      end else begin
         ev_valid = 1'b0;
         ev_word  = 6'h00;
      end
   end
   // a full queue drops new events; receive keeps running
   wire push = ev_valid && qcount != 4'(QDEPTH); // RULE4
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wptr   <= 3'h0;
         rptr   <= 3'h0;
         qcount <= 4'h0;
      end else begin
         if (push) wptr <= wptr + 3'h1;
         if (pop)  rptr <= rptr + 3'h1;
         qcount <= qcount + {3'h0, push} - {3'h0, pop};
      end
   end
   event_queue_mem #(.WIDTH(6), .DEPTH(QDEPTH), .AW(3)) u_queue (
      .hclk  (hclk),
      .we    (push),
      .waddr (wptr),
      .wdata (ev_word),
      .raddr (pop ? rptr + 3'h1 : rptr),
      .rdata (qrdata)
   );

   ////////////////////////////////////////////////////////////////
   // checks
   a_onr_abort: assert property (@(posedge hclk) disable iff (!hresetn) // RULE13
      err_onr |=> tx_state == TX_ABORT) else $error("no abort after ownership error");
   a_abort_hold: assert property (@(posedge hclk) disable iff (!hresetn) // RULE20
      tx_state == TX_ABORT && !reactivate |=> tx_state == TX_ABORT) else $error("abort left");
   a_poll_stop: assert property (@(posedge hclk) disable iff (!hresetn) // RULE15
      (err_onr || err_fifo) |=> !poll_enable) else $error("polling after error");
   a_no_status: assert property (@(posedge hclk) disable iff (!hresetn) // RULE14
      err_onr |-> !status_write_enable) else $error("status written on error");
   a_filt_drop: assert property (@(posedge hclk) disable iff (!hresetn) // RULE8
      ev_filt |-> msg_drop && msg_len >= 4'h3 && msg_len <= 4'h5) else $error("drop wrong");
   a_inc_count: assert property (@(posedge hclk) disable iff (!hresetn) // RULE5
      ev_inc && error_count < 8'hff |=> error_count == $past(error_count) + 8'h01)
      else $error("counter not incremented");
   a_dec_count: assert property (@(posedge hclk) disable iff (!hresetn) // RULE6
      ev_dec && !ev_inc |=> error_count == $past(error_count) - 8'h01 && clean_count == 9'h0)
      else $error("counter not decremented");
   a_tx_dir: assert property (@(posedge hclk) disable iff (!hresetn) // RULE19
      push && ev_word[4] |-> ev_word[5]) else $error("transmit error direction");
   a_abort_ones: assert property (@(posedge hclk) disable iff (!hresetn) // RULE13
      tx_state == TX_ABORT ##1 tx_state == TX_ABORT && bit_needed |=> tx_abort_bit)
      else $error("abort bit low");
   c_onr: cover property (@(posedge hclk) disable iff (!hresetn) err_onr);
   c_fifo: cover property (@(posedge hclk) disable iff (!hresetn) err_fifo);
   c_filt: cover property (@(posedge hclk) disable iff (!hresetn) ev_filt);
   c_idle: cover property (@(posedge hclk) disable iff (!hresetn) ev_abort ##[1:50] ev_idle);
endmodule // hdlc_channel_event_errors

/* File: common/hdlc_event_defs.svh */
// offsets, field positions, reset values and timing counts for the channel event block
`ifndef HDLC_EVENT_DEFS_SVH
`define HDLC_EVENT_DEFS_SVH
`define OFS_CHAN_CFG    8'h00
`define OFS_RX_STATUS   8'h04
`define OFS_TX_STATUS   8'h08
`define OFS_EVT_QUEUE   8'h0c
`define OFS_EVT_COUNT   8'h10
`define BIT_IDLE_MASK   0
`define BIT_FLOSS_MASK  1
`define BIT_INC_MASK    2
`define BIT_DEC_MASK    3
`define BIT_FILT_MASK   4
`define BIT_BUFERR_MASK 5
`define BIT_SS7_MODE    6
`define BIT_REACTIVATE  7
`define CHAN_CFG_RESET  32'h0000_0000
`define FILL_OCTET      8'h7e
`define ABORT_OCTET     8'hfe
`define CLEAN_RUN       9'h100
`define ABORT_ONES      5'h10
`define MIN_FILT_LEN    4'h3
`define MAX_FILT_LEN    4'h5
`endif

/* File: common/hdlc_event_pkg.sv */
// types for the channel event block
package hdlc_event_pkg;
   typedef enum logic [4:0] {
      EV_CHANGE_ABORT = 5'h01,
      EV_CHANGE_IDLE  = 5'h02,
      EV_FRAME_REC    = 5'h03,
      EV_INCREMENT    = 5'h04,
      EV_DECREMENT    = 5'h05,
      EV_FILTERED     = 5'h06,
      ER_OWNERSHIP    = 5'h10,
      ER_FIFO_RUN     = 5'h11
   } event_code_t;
   typedef enum logic [2:0] {
      TX_IDLE  = 3'b001,
      TX_RUN   = 3'b010,
      TX_ABORT = 3'b100
   } tx_state_t;
endpackage

/* File: core/event_queue_mem.sv */
// small event descriptor memory with registered read data
module event_queue_mem #(
   parameter int WIDTH = 6,
   parameter int DEPTH = 8,
   parameter int AW    = 3
) (
   input  wire logic             hclk,
   input  wire logic             we,
   input  wire logic [AW-1:0]    waddr,
   input  wire logic [WIDTH-1:0] wdata,
   input  wire logic [AW-1:0]    raddr,
   output logic      [WIDTH-1:0] rdata
);
   logic [WIDTH-1:0] mem [DEPTH];
   // write port
   always_ff @(posedge hclk) begin
      if (we) begin
         mem[waddr] <= wdata;
      end
   end
   // read data from a register
   always_ff @(posedge hclk) begin
      rdata <= mem[raddr];
   end
endmodule // event_queue_mem

/* File: test/tx_host_model.sv */
// far-side model: host descriptor ownership and serial bit demand for transmit
module tx_host_model (
   input  wire logic       hclk,
   input  wire logic       hresetn,
   input  wire logic       fetch_enable,
   input  wire logic       eom_cfg,
   input  wire logic       own_cfg,
   input  wire logic       starve,
   input  wire logic [3:0] blen,
   output logic            buf_done,
   output logic            end_of_message_flag,
   output logic            next_owned,
   output logic            fifo_empty,
   output logic            bit_needed
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [3:0] left;
   ////////////////////////////////////////
   // a granted buffer is never taken back, only finished after blen cycles
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         left <= 4'h0;
         buf_done <= 1'b0;
         bit_needed <= 1'b0;
      end else begin
         buf_done <= fetch_enable && left == 4'h1;
         left <= (!fetch_enable || left == 4'h1) ? blen : left - 4'h1;
         bit_needed <= !bit_needed; // serial side slower than hclk
      end
   end
   // flags mean nothing outside buf_done, so show the wrong value there
   assign end_of_message_flag = buf_done ? eom_cfg : !eom_cfg;
   assign next_owned = buf_done ? own_cfg : !own_cfg;
   assign fifo_empty = starve && fetch_enable;
endmodule // tx_host_model

/* File: test/hdlc_channel_event_errors_bench.sv */
// self-checking bench for the channel event and transmit error block
`include "hdlc_event_defs.svh"
module hdlc_channel_event_errors_bench import hdlc_event_pkg::*;;
   timeunit 1ns;
   timeprecision 1ns;
   logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, r;
   logic [1:0]  htrans = 2'h0;
   logic [2:0]  hsize = 3'h2;
   logic        hready, hreadyout, hresp, msg_drop, drop;
   logic        rx_octet_valid = 1'b0, in_frame = 1'b1, msg_end = 1'b0, msg_error = 1'b0;
   logic [7:0]  rx_octet = 8'h00;
   logic [3:0]  msg_len = 4'h0, blen = 4'h4;
   logic [39:0] msg_data = 40'h0, d;
   logic        buf_done, end_of_message_flag, next_owned, fifo_empty, bit_needed;
   logic        fetch_enable, poll_enable, status_write_enable, tx_abort_bit;
   logic        eom_cfg = 1'b0, own_cfg = 1'b0, starve = 1'b0;
   int          n_errors = 0, n_tests = 0, cyc = 0, swe = 0, seed = 39, s;
   assign hready = hreadyout;
   always #50 hclk = ~hclk;
   hdlc_channel_event_errors dut (
      .hclk                (hclk),
      .hresetn             (hresetn),
      .hsel                (hsel),
      .haddr               (haddr),
      .htrans              (htrans),
      .hwrite              (hwrite),
      .hsize               (hsize),
      .hwdata              (hwdata),
      .hready              (hready),
      .hreadyout           (hreadyout),
      .hresp               (hresp),
      .hrdata              (hrdata),
      .rx_octet_valid      (rx_octet_valid),
      .rx_octet            (rx_octet),
      .in_frame            (in_frame),
      .msg_end             (msg_end),
      .msg_error           (msg_error),
      .msg_len             (msg_len),
      .msg_data            (msg_data),
      .msg_drop            (msg_drop),
      .buf_done            (buf_done),
      .end_of_message_flag (end_of_message_flag),
      .next_owned          (next_owned),
      .fifo_empty          (fifo_empty),
      .bit_needed          (bit_needed),
      .fetch_enable        (fetch_enable),
      .poll_enable         (poll_enable),
      .status_write_enable (status_write_enable),
      .tx_abort_bit        (tx_abort_bit)
   );
   tx_host_model partner (
      .hclk                (hclk),
      .hresetn             (hresetn),
      .fetch_enable        (fetch_enable),
      .eom_cfg             (eom_cfg),
      .own_cfg             (own_cfg),
      .starve              (starve),
      .blen                (blen),
      .buf_done            (buf_done),
      .end_of_message_flag (end_of_message_flag),
      .next_owned          (next_owned),
      .fifo_empty          (fifo_empty),
      .bit_needed          (bit_needed)
   );
   ////////////////////////////////////////
   // hang guard and status-write activity count
   always @(posedge hclk) begin
      cyc <= cyc + 1;
      if (cyc == 40000) begin
         n_errors++;
         end_of_test();
      end
   end
   always @(negedge hclk) if (status_write_enable === 1'b1) swe++;
   task automatic end_of_test();
      $display("errors %0d checks %0d", n_errors, n_tests);
      if (n_errors == 0 && n_tests > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         n_errors++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   ////////////////////////////////////////
   // one ahb single transfer; two idle edges first keep queue pops spaced
   task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] wd);
      int k;
      k = 0;
      repeat (2) @(posedge hclk);
      hsel <= 1'b1;
      htrans <= 2'b10;
      haddr <= a;
      hwrite <= w;
      do @(posedge hclk); while (hready !== 1'b1 && ++k < 50);
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= wd;
      do @(posedge hclk); while (hready !== 1'b1 && ++k < 100);
      r = hrdata;
      if (hready !== 1'b1) n_errors++; // bus wait limit ran out
   endtask
   task automatic rd(input logic [31:0] a);
      ahb(1'b0, a, 32'h0);
   endtask
   task automatic oct(input logic [7:0] o);
      @(posedge hclk);
      rx_octet <= o;
      rx_octet_valid <= 1'b1;
      @(posedge hclk);
      rx_octet_valid <= 1'b0;
      rx_octet <= ~o;
   endtask
   // data fields are turned to garbage outside the end pulse
   task automatic msg(input logic e, input logic [3:0] l, input logic [39:0] v);
      @(posedge hclk);
      msg_end <= 1'b1;
      msg_error <= e;
      msg_len <= l;
      msg_data <= v;
      @(negedge hclk);
      drop = msg_drop;
      @(posedge hclk);
      msg_end <= 1'b0;
      msg_error <= !e;
      msg_data <= ~v;
   endtask
   task automatic waitq();
      int k;
      k = 0;
      do begin
         rd(`OFS_EVT_COUNT);
         k++;
      end while (r === 32'h0 && k < 60);
      if (r === 32'h0) n_errors++; // no event within the wait limit
   endtask
   // expected queue entry: valid, direction from the transmit code range
   function automatic logic [31:0] ev(input event_code_t c);
      return {25'h0, 1'b1, c[4], c};
   endfunction
   ////////////////////////////////////////
   initial begin
      repeat (5) @(posedge hclk);
      hresetn <= 1'b1;
      rd(`OFS_TX_STATUS);
      check("tx idle", r[3:0], 32'h2);
      check("hresp", hresp, 32'h0);
      oct(`FILL_OCTET);
      oct(`ABORT_OCTET);
      rd(`OFS_EVT_QUEUE);
      check("to abort", r, ev(EV_CHANGE_ABORT));
      oct(`FILL_OCTET);
      rd(`OFS_EVT_QUEUE);
      check("to idle", r, ev(EV_CHANGE_IDLE));
      ahb(1'b1, `OFS_CHAN_CFG, 32'h1);
      oct(`ABORT_OCTET);
      oct(`FILL_OCTET);
      rd(`OFS_EVT_COUNT);
      check("idle masked", r, 32'h0);
      for (int m = 0; m < 2; m++) begin
         ahb(1'b1, `OFS_CHAN_CFG, m << `BIT_FLOSS_MASK);
         @(posedge hclk) in_frame <= 1'b0;
         @(posedge hclk) in_frame <= 1'b1;
         rd(`OFS_EVT_COUNT);
         check("frame rec", r, 32'h1 - m);
         if (m == 0) rd(`OFS_EVT_QUEUE);
         if (m == 0) check("frame ev", r, ev(EV_FRAME_REC));
      end
      // ss7: error count, 256 clean messages, duplicate filter window
      ahb(1'b1, `OFS_CHAN_CFG, 32'h44);
      msg(1'b1, 4'h8, 40'h1);
      rd(`OFS_EVT_COUNT);
      check("inc masked", r, 32'h0);
      ahb(1'b1, `OFS_CHAN_CFG, 32'h40);
      msg(1'b1, 4'h8, 40'h2);
      rd(`OFS_EVT_QUEUE);
      check("inc ev", r, ev(EV_INCREMENT));
      rd(`OFS_RX_STATUS);
      check("err cnt 2", r, 32'h5);
      // second clean run has the decrement mask set
      for (int p = 0; p < 2; p++) begin
         if (p == 1) ahb(1'b1, `OFS_CHAN_CFG, 32'h48);
         for (int i = 0; i < 256; i++) begin
            d = {$random(seed), $random(seed)};
            msg(1'b0, 4'h8, d);
            if (i == 254) rd(`OFS_EVT_COUNT);
            if (i == 254) check("no early dec", r, 32'h0);
         end
         if (p == 0) rd(`OFS_EVT_QUEUE);
         else rd(`OFS_EVT_COUNT);
         check("dec ev", r, p == 0 ? ev(EV_DECREMENT) : 32'h0);
         rd(`OFS_RX_STATUS);
         check("err cnt", r, 32'h3 - 2 * p);
      end
      for (int l = 2; l < 7; l++) begin
         d = {$random(seed), $random(seed)};
         msg(1'b0, l[3:0], d);
         msg(1'b0, l[3:0], d);
         check("drop", drop, l >= 3 && l <= 5);
         if (l >= 3 && l <= 5) rd(`OFS_EVT_QUEUE);
         if (l >= 3 && l <= 5) check("filt ev", r, ev(EV_FILTERED));
      end
      ahb(1'b1, `OFS_CHAN_CFG, 32'h50);
      msg(1'b0, 4'h4, 40'h5);
      msg(1'b0, 4'h4, 40'h5);
      check("drop masked", drop, 32'h1);
      rd(`OFS_EVT_COUNT);
      check("filt none", r, 32'h0);
      // transmit: ownership underflow, normal run, fifo under-run, masked
      ahb(1'b1, `OFS_CHAN_CFG, 32'h80);
      waitq();
      rd(`OFS_EVT_QUEUE);
      check("own err", r, ev(ER_OWNERSHIP));
      check("no status", swe, 32'h0);
      check("no poll", {fetch_enable, poll_enable}, 32'h0);
      repeat (20) begin
         @(negedge hclk);
         check("ones", tx_abort_bit, 32'h1);
      end
      rd(`OFS_TX_STATUS);
      check("abort st", r[3:0], 32'h8);
      eom_cfg <= 1'b1;
      own_cfg <= 1'b1;
      blen <= 4'h3; // odd length walks buffer ends across both bit phases
      ahb(1'b1, `OFS_CHAN_CFG, 32'h80);
      repeat (30) begin
         @(negedge hclk);
         check("fetch", fetch_enable, 32'h1);
      end
      check("status wr", swe > 0, 32'h1);
      // starve in the cycle a buffer ends, so status write and under-run coincide
      do @(posedge hclk); while (!(buf_done === 1'b1 && bit_needed === 1'b0));
      repeat (2) @(posedge hclk);
      s = swe;
      starve <= 1'b1;
      waitq();
      rd(`OFS_EVT_QUEUE);
      check("fifo err", r, ev(ER_FIFO_RUN));
      rd(`OFS_TX_STATUS);
      check("abort st2", r[3:0], 32'h8);
      check("no status2", swe - s, 32'h0);
      ahb(1'b1, `OFS_CHAN_CFG, 32'ha0);
      repeat (10) @(posedge hclk);
      rd(`OFS_EVT_COUNT);
      check("buf masked", r, 32'h0);
      rd(`OFS_TX_STATUS);
      check("abort st3", r[3:0], 32'h8);
      end_of_test();
   end
endmodule // hdlc_channel_event_errors_bench
